// >>> src/sgar_status.sv
// sgmii negotiation result status register bank with avalon-mm slave
// Summary of operation
// - bit 4 reads the link state reported by the partner, 1 means up.
// - bits 3:2 read partner speed: 00 10M, 01 100M, 10 1000M, 11 reserved.
// - bit 1 reads partner duplex, 0 half and 1 full.
// - link, speed and duplex are taken only from sgmii-mode negotiations.
// - bit 0 is set when negotiation finishes and stays set until cleared.
// - software clears bit 0 by writing zero; otherwise only reset clears it.
// - the completion flag sets regardless of the interrupt enable bit.
// - completion interrupt reaches the output only while the enable bit is 1.
`timescale 1ns/1ns
`default_nettype none

module sgar_status
    import sgar_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    // avalon-mm slave
    input wire logic [sgar_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [sgar_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [sgar_pkg::BE_W-1:0] avs_byteenable_in,
    output logic [sgar_pkg::DATA_W-1:0] avs_readdata_out,
    output logic [1:0] avs_response_out,
    output logic avs_waitrequest_out,
    // results from the negotiation engine, same clock
    input wire logic an_done_in,
    input wire logic partner_link_in,
    input wire logic [sgar_pkg::RES_SPEED_W-1:0] partner_speed_in,
    input wire logic partner_duplex_in,
    // to the negotiation engine and the interrupt controller
    output logic [sgar_pkg::GATE_MODE_W-1:0] an_mode_out,
    output logic irq_out
);
    import sgar_pkg::*;

    // ---------------------------------------------------------------
    // bus handshake
    // ---------------------------------------------------------------
    sgar_bus_t bus_ff;
    sgar_bus_t nxt_bus;
    logic wait_ff;
    logic nxt_wait;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [1:0] resp_ff;
    logic [1:0] nxt_resp;

    wire bus_req = avs_read_in | avs_write_in;
    // a request is committed at the edge where the master sees waitrequest low
    wire bus_commit = bus_req & (bus_ff == BUS_ANSWER);
    wire wr_commit = avs_write_in & bus_commit;

    wire hit_result = (avs_address_in == ADDR_RESULT);
    wire hit_gate = (avs_address_in == ADDR_GATE);
    wire hit_irq_status = (avs_address_in == ADDR_IRQ_STATUS);
    wire hit_irq_mask = (avs_address_in == ADDR_IRQ_MASK);
    wire hit_any = hit_result | hit_gate | hit_irq_status | hit_irq_mask;

    // byte lane 0 carries every writable bit in this bank
    wire lane0 = avs_byteenable_in[0];

    wire wr_result = wr_commit & hit_result & lane0;
    wire wr_gate = wr_commit & hit_gate & lane0;
    wire wr_irq_status = wr_commit & hit_irq_status & lane0;
    wire wr_irq_mask = wr_commit & hit_irq_mask & lane0;

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic link_ff;
    logic nxt_link;
    logic [RES_SPEED_W-1:0] speed_ff;
    logic [RES_SPEED_W-1:0] nxt_speed;
    logic duplex_ff;
    logic nxt_duplex;
    logic done_ff;
    logic nxt_done;
    logic gate_en_ff;
    logic nxt_gate_en;
    logic [GATE_MODE_W-1:0] mode_ff;
    logic [GATE_MODE_W-1:0] nxt_mode;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] nxt_irq_status;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [IRQ_W-1:0] nxt_irq_mask;
    logic irq_ff;
    logic nxt_irq;

    // ---------------------------------------------------------------
    // negotiation results
    // ---------------------------------------------------------------
    wire sgmii_mode = (mode_ff == MODE_SGMII);
    // serdes / 1000base-x results live elsewhere, so only sgmii updates the fields
    wire take_result = an_done_in & sgmii_mode;
    wire link_change = take_result & (partner_link_in != link_ff);

    // completion flag: a zero written to bit 0 clears it, a one does nothing
    wire done_clear = wr_result & ~avs_writedata_in[RES_DONE_BIT];

    // w1c on the interrupt status register
    wire [IRQ_W-1:0] irq_w1c = wr_irq_status ? avs_writedata_in[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irq_events = {link_change, an_done_in};

    // completion interrupt is gated by the enable, link change by its mask only
    wire [IRQ_W-1:0] irq_gate = {1'b1, gate_en_ff};
    wire irq_pending = |(irq_status_ff & irq_mask_ff & irq_gate);

    // ---------------------------------------------------------------
    // read data assembly
    // ---------------------------------------------------------------
    wire [REG_W-1:0] result_word = {
        {(REG_W-RES_USED_W){1'b0}},
        link_ff,
        speed_ff,
        duplex_ff,
        done_ff
    };
    wire [REG_W-1:0] gate_word = {
        {(REG_W-GATE_MODE_W-1){1'b0}},
        mode_ff,
        gate_en_ff
    };
    wire [REG_W-1:0] irq_status_word = {{(REG_W-IRQ_W){1'b0}}, irq_status_ff};
    wire [REG_W-1:0] irq_mask_word = {{(REG_W-IRQ_W){1'b0}}, irq_mask_ff};

    wire [REG_W-1:0] read_mux =
        hit_result ? result_word :
        hit_gate ? gate_word :
        hit_irq_status ? irq_status_word :
        hit_irq_mask ? irq_mask_word : '0;

    // upper half of the word always reads zero
    wire [DATA_W-1:0] read_word = {{(DATA_W-REG_W){1'b0}}, read_mux};

    // ---------------------------------------------------------------
    // next-state logic: bus
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_bus = bus_ff;
        nxt_wait = wait_ff;
        nxt_rdata = rdata_ff;
        nxt_resp = resp_ff;
        case (bus_ff)
            BUS_IDLE:
            begin
                // data captured here is held through the answer edge
                if (bus_req)
                begin
                    nxt_bus = BUS_ANSWER;
                    nxt_wait = 1'b0;
                    nxt_rdata = avs_read_in ? read_word : '0;
                    nxt_resp = hit_any ? RESP_OKAY : RESP_DECODEERROR;
                end
            end
            BUS_ANSWER:
            begin
                // one answer cycle, then back to stalling
                nxt_bus = BUS_IDLE;
                nxt_wait = 1'b1;
            end
            default:
            begin
                nxt_bus = BUS_IDLE;
                nxt_wait = 1'b1;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // next-state logic: result fields
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_link = link_ff;
        nxt_speed = speed_ff;
        nxt_duplex = duplex_ff;
        if (take_result)
        begin
            nxt_link = partner_link_in;
            nxt_speed = partner_speed_in;
            nxt_duplex = partner_duplex_in;
        end
    end

    // ---------------------------------------------------------------
    // next-state logic: completion flag
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_done = done_ff;
        if (done_clear)
        begin
            nxt_done = 1'b0;
        end
        // set wins over a clear in the same cycle; enable plays no part
        if (an_done_in)
        begin
            nxt_done = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // next-state logic: gate and interrupt registers
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_gate_en = gate_en_ff;
        nxt_mode = mode_ff;
        nxt_irq_mask = irq_mask_ff;
        if (wr_gate)
        begin
            nxt_gate_en = avs_writedata_in[GATE_EN_BIT];
            nxt_mode = avs_writedata_in[GATE_MODE_LSB +: GATE_MODE_W];
        end
        if (wr_irq_mask)
        begin
            nxt_irq_mask = avs_writedata_in[IRQ_W-1:0];
        end
        // event set beats a simultaneous w1c
        nxt_irq_status = (irq_status_ff & ~irq_w1c) | irq_events;
        nxt_irq = irq_pending;
    end

    // ---------------------------------------------------------------
    // flip-flops
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            bus_ff <= BUS_IDLE;
            wait_ff <= 1'b1;
            rdata_ff <= '0;
            resp_ff <= RESP_OKAY;
        end
        else
        begin
            bus_ff <= nxt_bus;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
            resp_ff <= nxt_resp;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            link_ff <= 1'b0;
            speed_ff <= SPEED_10;
            duplex_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            link_ff <= nxt_link;
            speed_ff <= nxt_speed;
            duplex_ff <= nxt_duplex;
            done_ff <= nxt_done;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            gate_en_ff <= 1'b0;
            mode_ff <= GATE_MODE_RESET;
            irq_status_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            gate_en_ff <= nxt_gate_en;
            mode_ff <= nxt_mode;
            irq_status_ff <= nxt_irq_status;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= nxt_irq;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flops
    // ---------------------------------------------------------------
    assign avs_readdata_out = rdata_ff;
    assign avs_response_out = resp_ff;
    assign avs_waitrequest_out = wait_ff;
    assign an_mode_out = mode_ff;
    assign irq_out = irq_ff;

endmodule

`default_nettype wire

// >>> pkg/sgar_pkg.sv
// constants for the sgmii negotiation result status block
package sgar_pkg;

    // avalon-mm geometry: byte addresses, one 32-bit word per register
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int REG_W = 16;

    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_RESULT = 24'h1F8002;
    localparam logic [ADDR_W-1:0] IDX_GATE = 24'h1F8010;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 24'h1F8011;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 24'h1F8012;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = {IDX_RESULT[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_GATE = {IDX_GATE[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[ADDR_W-3:0], 2'h0};

    // result register fields
    localparam int RES_LINK_BIT = 4;
    localparam int RES_SPEED_LSB = 2;
    localparam int RES_SPEED_W = 2;
    localparam int RES_DUPLEX_BIT = 1;
    localparam int RES_DONE_BIT = 0;
    localparam int RES_USED_W = 5;

    // gate register fields: completion interrupt enable and negotiation mode
    localparam int GATE_EN_BIT = 0;
    localparam int GATE_MODE_LSB = 1;
    localparam int GATE_MODE_W = 2;
    localparam logic [1:0] MODE_SERDES = 2'h0;
    localparam logic [1:0] MODE_SGMII = 2'h2;
    localparam logic [1:0] GATE_MODE_RESET = MODE_SGMII;

    // speed codes as reported by the partner
    localparam logic [1:0] SPEED_10 = 2'h0;
    localparam logic [1:0] SPEED_100 = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // interrupt status / mask layout
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_LINK_BIT = 1;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODEERROR = 2'h3;

    // bus handshake phases
    typedef enum logic {BUS_IDLE, BUS_ANSWER} sgar_bus_t;

endpackage

// >>> tb/sgar_monitor.sv
// assertion checker for the negotiation result status bank
`timescale 1ns/1ns
`default_nettype none
module sgar_monitor
    import sgar_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [sgar_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [sgar_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [sgar_pkg::BE_W-1:0] avs_byteenable_in,
    input wire logic [sgar_pkg::DATA_W-1:0] avs_readdata_out,
    input wire logic [1:0] avs_response_out,
    input wire logic avs_waitrequest_out,
    input wire logic an_done_in,
    input wire logic partner_link_in,
    input wire logic [sgar_pkg::RES_SPEED_W-1:0] partner_speed_in,
    input wire logic partner_duplex_in,
    input wire logic [sgar_pkg::GATE_MODE_W-1:0] an_mode_out,
    input wire logic irq_out
);
    import sgar_pkg::*;
    logic en_ff;
    logic flag_ff;
    logic [1:0] mask_ff;
    logic [3:0] res_ff;
    wire req = (avs_read_in || avs_write_in) && avs_waitrequest_out;
    wire commit = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    wire mapped = avs_address_in == ADDR_RESULT || avs_address_in == ADDR_GATE
        || avs_address_in == ADDR_IRQ_STATUS || avs_address_in == ADDR_IRQ_MASK;
    wire rd_res = avs_read_in && avs_waitrequest_out && avs_address_in == ADDR_RESULT;
    wire clr = commit && avs_address_in == ADDR_RESULT && !avs_writedata_in[0];
    wire may_irq = en_ff && mask_ff[0] || mask_ff[1];
    // shadow of the bank, so reads can be judged without peeking inside
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            en_ff <= 1'b0;
            flag_ff <= 1'b0;
            mask_ff <= 2'h0;
            res_ff <= 4'h0;
        end
        else
        begin
            if (commit && avs_address_in == ADDR_GATE)
                en_ff <= avs_writedata_in[0];
            if (commit && avs_address_in == ADDR_IRQ_MASK)
                mask_ff <= avs_writedata_in[1:0];
            if (an_done_in || clr)
                flag_ff <= an_done_in;
            if (an_done_in && an_mode_out == MODE_SGMII)
                res_ff <= {partner_link_in, partner_speed_in, partner_duplex_in};
        end
    end
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    wait_one_a: assert property (req |=> !avs_waitrequest_out)
        else $error("waitrequest not low one cycle after request");
    wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    unmapped_resp_a: assert property (req && !mapped |=> avs_response_out == RESP_DECODEERROR)
        else $error("unmapped access not answered with decode error");
    reserved_zero_a: assert property (rd_res |=> avs_readdata_out[15:5] == 11'h000)
        else $error("reserved result bits not zero");
    field_read_a: assert property (rd_res |=> avs_readdata_out[4:1] == $past(res_ff))
        else $error("link speed duplex fields wrong");
    flag_read_a: assert property (rd_res |=> avs_readdata_out[0] == $past(flag_ff))
        else $error("completion flag wrong");
    irq_gate_a: assert property (irq_out |-> $past(may_irq))
        else $error("interrupt without enable");
    done_irq_a: assert property (an_done_in && en_ff && mask_ff[0] |-> ##2 irq_out)
        else $error("interrupt missing after completion");
    cover property (rd_res);
    cover property (an_done_in && !en_ff);
    cover property (req && !mapped);
endmodule
bind sgar_status sgar_monitor u_mon (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_response_out(avs_response_out), .avs_waitrequest_out(avs_waitrequest_out),
    .an_done_in(an_done_in), .partner_link_in(partner_link_in),
    .partner_speed_in(partner_speed_in), .partner_duplex_in(partner_duplex_in),
    .an_mode_out(an_mode_out), .irq_out(irq_out));
`default_nettype wire

// >>> tb/sgar_partner.sv
// model of the link partner reporting a negotiation outcome
`timescale 1ns/1ns
`default_nettype none
module sgar_partner (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic [3:0] delay_in,
    input wire logic [3:0] result_in,
    output logic an_done_out,
    output logic [3:0] report_out
);
    logic [4:0] cnt_ff;
    logic [3:0] held_ff;
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            cnt_ff <= 5'h00;
        else if (start_in)
            cnt_ff <= {1'b0, delay_in} + 5'h01;
        else if (cnt_ff != 5'h00)
            cnt_ff <= cnt_ff - 5'h01;
        if (start_in)
            held_ff <= result_in;
    end
    assign an_done_out = cnt_ff == 5'h01;
    // outside the pulse show the inverse, so late sampling is caught
    assign report_out = an_done_out ? held_ff : ~held_ff;
endmodule
`default_nettype wire

// >>> tb/sgmii_autoneg_result_status_tb_top.sv
// self-checking bench for the negotiation result status bank
`timescale 1ns/1ns
`default_nettype none
module sgmii_autoneg_result_status_tb_top;
    import sgar_pkg::*;
    logic clk_in, rstn_in, avs_read_in, avs_write_in, avs_waitrequest_out;
    logic [ADDR_W-1:0] avs_address_in;
    logic [BE_W-1:0] avs_byteenable_in;
    logic [DATA_W-1:0] avs_writedata_in, avs_readdata_out;
    logic [1:0] avs_response_out, an_mode_out;
    logic an_done_in, irq_out, start;
    logic [3:0] delay, result, report;
    int error_cnt, check_count;
    sgar_status u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_response_out(avs_response_out),
        .avs_waitrequest_out(avs_waitrequest_out), .an_done_in(an_done_in),
        .partner_link_in(report[3]), .partner_speed_in(report[2:1]),
        .partner_duplex_in(report[0]), .an_mode_out(an_mode_out), .irq_out(irq_out));
    sgar_partner u_phy (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start),
        .delay_in(delay), .result_in(result), .an_done_out(an_done_in), .report_out(report));
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        // look between edges so the answer edge is never raced
        @(negedge clk_in);
        while (avs_waitrequest_out !== 1'b0 && n < 50)
        begin
            @(negedge clk_in);
            n++;
        end
        q = avs_readdata_out;
        r = avs_response_out;
        @(posedge clk_in);
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (n >= 50)
            error_cnt++;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, a, d, q, r);
    endtask
    task automatic rd(input logic [23:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, a, 32'h0, q, r);
        check(nm, {r, q[29:0]}, {RESP_OKAY, e[29:0]});
    endtask
    task automatic negotiate(input logic [3:0] res, input logic [3:0] dl, input logic ei);
        int n;
        n = 0;
        start <= 1'b1;
        delay <= dl;
        result <= res;
        @(posedge clk_in);
        start <= 1'b0;
        @(negedge clk_in);
        while (an_done_in !== 1'b1 && n < 40)
        begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 40)
            error_cnt++;
        repeat (2) @(posedge clk_in);
        #1 check("irq", {31'h0, irq_out}, {31'h0, ei});
        @(posedge clk_in);
    endtask
    task automatic test_reset();
        logic [31:0] q;
        logic [1:0] r;
        rd(ADDR_RESULT, 32'h0, "result reset");
        rd(ADDR_GATE, 32'h4, "gate reset");
        bus(1'b0, 24'h000010, 32'h0, q, r);
        check("unmapped", {r, q[29:0]}, {RESP_DECODEERROR, 30'h0});
    endtask
    task automatic test_complete();
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_GATE, 32'h5);
        negotiate(4'hD, 4'h1, 1'b1);
        rd(ADDR_RESULT, 32'h1B, "fields");
        wr(ADDR_RESULT, 32'hFFFFFFFF);
        rd(ADDR_RESULT, 32'h1B, "write one");
        // zero written with lane 0 disabled must not clear the flag
        avs_byteenable_in <= 4'hE;
        wr(ADDR_RESULT, 32'h0);
        avs_byteenable_in <= 4'hF;
        rd(ADDR_RESULT, 32'h1B, "lane off");
        wr(ADDR_RESULT, 32'h0);
        rd(ADDR_RESULT, 32'h1A, "clear");
        wr(ADDR_IRQ_STATUS, 32'h3);
        @(negedge clk_in);
        check("irq clear", {31'h0, irq_out}, 32'h0);
        @(posedge clk_in);
    endtask
    task automatic test_no_enable();
        // software reprograms control before the negotiation, then reads the results
        wr(ADDR_GATE, 32'h4);
        negotiate(4'h3, 4'h9, 1'b0);
        rd(ADDR_RESULT, 32'h07, "flag no enable");
        wr(ADDR_IRQ_STATUS, 32'h3);
    endtask
    task automatic test_speeds();
        for (int i = 0; i < 3; i++)
        begin
            negotiate({1'b1, i[1:0], 1'b0}, 4'h2, 1'b0);
            rd(ADDR_RESULT, {27'h0, 1'b1, i[1:0], 2'h1}, "speed");
        end
    endtask
    task automatic test_serdes();
        // serdes results are not taken from this register
        wr(ADDR_GATE, 32'h0);
        wr(ADDR_RESULT, 32'h0);
        check("mode", {30'h0, an_mode_out}, {30'h0, MODE_SERDES});
        negotiate(4'h0, 4'h3, 1'b0);
        rd(ADDR_RESULT, 32'h19, "serdes kept");
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial
    begin
        {rstn_in, avs_read_in, avs_write_in, start} = 4'h0;
        {avs_address_in, avs_writedata_in, delay, result} = '0;
        avs_byteenable_in = 4'hF;
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        test_reset();
        test_complete();
        test_no_enable();
        test_speeds();
        test_serdes();
        complete_run();
    end
    // the whole sequence needs about 120 cycles
    initial
    begin
        #200000;
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
